// ==== hw/lpa_channel.sv ====
// linear pulse accumulator channel: command scanner, accumulator and buffers
`timescale 1ns/10ps
module lpa_channel import lpa_pkg::*; #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // tach phases, synchronous
   input wire logic tach_a_i,
   input wire logic tach_b_i,
   // command input buffer
   input wire lpa_byte_t cmd_in_i,
   output logic cmd_full_o,
   // result output buffer
   output lpa_word_t result_out_o,
   input wire logic result_take_i,
   // channel status buffer
   output lpa_byte_t status_out_o,
   input wire logic status_take_i,
   input wire logic irq_hw_en_i,
   output logic irq_o,
   // observed state
   output logic running_o,
   output logic linear_mode_o
);
   // ====================================================
   // state
   lpa_state_t st_r, st_nxt;
   logic [3:0] pcnt_r, pcnt_nxt;
   logic [7:0] sel_r, sel_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   // working copy of the command under execution, so a byte that lands in the
   // buffer during a read wait cannot overwrite the bits still to be scanned
   logic [7:0] exe_r, exe_nxt;
   logic lin_r, lin_nxt;
   logic cmd_full_r, cmd_full_nxt;
   logic run_r, run_nxt;
   logic [CNT_W-1:0] lo_r, lo_nxt, hi_r, hi_nxt;
   logic [CNT_W-1:0] cap_lo_r, cap_lo_nxt;
   lpa_word_t res_r, res_nxt;
   lpa_byte_t stat_r, stat_nxt;
   logic irq_r, irq_nxt;
   logic a_d_r, b_d_r;

   // ====================================================
   // edge qualification
   function automatic logic edge_ok(input logic [1:0] rate, input logic ea, input logic eb,
                                    input logic ra);
      case (rate)
         LPA_RATE_X1: edge_ok = ra; // rising phase A only
         LPA_RATE_X2: edge_ok = ea;
         LPA_RATE_X4: edge_ok = ea | eb;
         default: edge_ok = 1'b0;
      endcase
   endfunction

   logic ea, eb, cnt_pulse;
   always_comb begin
      ea = tach_a_i ^ a_d_r;
      eb = tach_b_i ^ b_d_r;
      // direction is never looked at
      cnt_pulse = run_r & edge_ok(sel_r[LPA_SEL_RATE_LO +: 2], ea, eb, ea & tach_a_i);
   end

   // ====================================================
   // next state
   logic [CNT_W:0] lo_sum;
   logic [7:0] post;
   always_comb begin
      st_nxt = st_r;
      pcnt_nxt = pcnt_r;
      sel_nxt = sel_r;
      cmd_nxt = cmd_r;
      exe_nxt = exe_r;
      cmd_full_nxt = cmd_full_r;
      run_nxt = run_r;
      cap_lo_nxt = cap_lo_r;
      res_nxt = res_r;
      stat_nxt = stat_r;
      post = 8'h00;
      lo_sum = {1'b0, lo_r} + {{CNT_W{1'b0}}, cnt_pulse};
      lo_nxt = lo_sum[CNT_W-1:0];
      hi_nxt = hi_r + CNT_W'(lo_sum[CNT_W]);
      if (res_r.valid && result_take_i) begin
         res_nxt.valid = 1'b0;
      end
      if (status_take_i) begin
         stat_nxt.valid = 1'b0;
      end
      // command buffer accepts a byte only when empty
      if (cmd_in_i.valid && !cmd_full_r) begin
         cmd_nxt = cmd_in_i.data;
         cmd_full_nxt = 1'b1;
      end
      case (st_r)
         LPA_ST_MODE: begin
            if (cmd_full_r) begin
               cmd_full_nxt = 1'b0;
               if (cmd_r == LPA_MODE_LINEAR) begin
                  st_nxt = LPA_ST_PARAM;
                  pcnt_nxt = 4'h0;
               end
            end
         end
         LPA_ST_PARAM: begin
            if (cmd_full_r) begin
               cmd_full_nxt = 1'b0;
               if (32'(pcnt_r) == LPA_INPUT_SELECT_BYTE_IDX) begin
                  sel_nxt = cmd_r;
               end
               pcnt_nxt = pcnt_r + 4'h1;
               if (32'(pcnt_r) == LPA_PARAM_LEN - 1) begin
                  st_nxt = LPA_ST_IDLE;
                  lo_nxt = '0;
                  hi_nxt = '0;
                  run_nxt = 1'b0;
               end
            end
         end
         LPA_ST_IDLE: begin
            if (cmd_full_r) begin
               cmd_full_nxt = 1'b0;
               if (cmd_r[LPA_CMD_NEWMODE]) begin
                  st_nxt = LPA_ST_MODE;
                  run_nxt = 1'b0;
               end else if ((cmd_r & LPA_CMD_RSVD_MASK) != 8'h00) begin
                  post[LPA_STAT_BADCMD] = 1'b1;
               end else begin
                  // zero byte falls through every bit test untouched
                  exe_nxt = cmd_r;
                  st_nxt = LPA_ST_SCAN;
               end
               if (st_nxt != LPA_ST_SCAN) begin
                  stat_nxt.data = (stat_r.valid & ~status_take_i) ? stat_r.data | post : post;
                  stat_nxt.valid = 1'b1;
               end
            end
         end
         LPA_ST_SCAN: begin
            // stop, read, reset, start in descending bit order
            if (exe_r[LPA_CMD_STOP]) begin
               run_nxt = 1'b0;
            end
            if (exe_r[LPA_CMD_READ]) begin
               // capture hi from the post-increment value so a low carry is included
               res_nxt.data = hi_nxt;
               res_nxt.valid = 1'b1;
               cap_lo_nxt = lo_nxt;
               st_nxt = LPA_ST_RD_HI;
            end else begin
               if (exe_r[LPA_CMD_RESET]) begin
                  lo_nxt = '0;
                  hi_nxt = '0;
               end
               if (exe_r[LPA_CMD_START]) begin
                  run_nxt = 1'b1;
               end
               st_nxt = LPA_ST_IDLE;
               stat_nxt.data = (stat_r.valid & ~status_take_i) ? stat_r.data : 8'h00;
               stat_nxt.valid = 1'b1;
            end
         end
         LPA_ST_RD_HI: begin
            if (result_take_i) begin
               res_nxt.data = cap_lo_r;
               res_nxt.valid = 1'b1;
               st_nxt = LPA_ST_RD_LO;
            end
         end
         LPA_ST_RD_LO: begin
            if (result_take_i) begin
               // remaining bits run once both words are gone
               exe_nxt[LPA_CMD_STOP] = 1'b0;
               exe_nxt[LPA_CMD_READ] = 1'b0;
               st_nxt = LPA_ST_SCAN;
            end
         end
         default: st_nxt = LPA_ST_MODE;
      endcase
      irq_nxt = irq_hw_en_i & sel_r[LPA_SEL_IRQ_STAT] & stat_nxt.valid &
                ((stat_nxt.data & LPA_STAT_ERR_MASK) != 8'h00);
      lin_nxt = (st_nxt != LPA_ST_MODE) && (st_nxt != LPA_ST_PARAM);
   end

   // ====================================================
   // registers
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= LPA_ST_MODE;
         pcnt_r <= 4'h0;
         sel_r <= 8'h00;
         cmd_r <= 8'h00;
         exe_r <= 8'h00;
         lin_r <= 1'b0;
         cmd_full_r <= 1'b0;
         run_r <= 1'b0;
         lo_r <= '0;
         hi_r <= '0;
         cap_lo_r <= '0;
         res_r <= '0;
         stat_r <= '0;
         irq_r <= 1'b0;
         a_d_r <= 1'b0;
         b_d_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         pcnt_r <= pcnt_nxt;
         sel_r <= sel_nxt;
         cmd_r <= cmd_nxt;
         exe_r <= exe_nxt;
         lin_r <= lin_nxt;
         cmd_full_r <= cmd_full_nxt;
         run_r <= run_nxt;
         lo_r <= lo_nxt;
         hi_r <= hi_nxt;
         cap_lo_r <= cap_lo_nxt;
         res_r <= res_nxt;
         stat_r <= stat_nxt;
         irq_r <= irq_nxt;
         a_d_r <= tach_a_i;
         b_d_r <= tach_b_i;
      end
   end

   always_comb begin
      cmd_full_o = cmd_full_r;
      result_out_o = res_r;
      status_out_o = stat_r;
      irq_o = irq_r;
      running_o = run_r;
      linear_mode_o = lin_r;
   end

   // ====================================================
   // checks
   wrap_to_zero_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_r == LPA_ST_IDLE && lo_r == '1 && hi_r == '1 && cnt_pulse && !cmd_full_r)
      |=> (lo_r == '0 && hi_r == '0)) else $error("accumulator did not wrap");
   stopped_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (!run_r && st_r == LPA_ST_IDLE && !cmd_full_r) |=> $stable(lo_r))
      else $error("stopped accumulator moved");
   params_clear_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_r == LPA_ST_PARAM && st_nxt == LPA_ST_IDLE) |=> (!run_r && lo_r == '0 && hi_r == '0))
      else $error("init did not clear");
   read_order_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_r == LPA_ST_RD_HI && result_take_i) |=> (st_r == LPA_ST_RD_LO && res_r.valid))
      else $error("low word not posted");
   bad_cmd_flag_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_r == LPA_ST_IDLE && cmd_full_r && !cmd_r[LPA_CMD_NEWMODE] &&
       (cmd_r & LPA_CMD_RSVD_MASK) != 8'h00)
      |=> (stat_r.valid && stat_r.data[LPA_STAT_BADCMD] && st_r == LPA_ST_IDLE))
      else $error("invalid command not flagged");
   start_runs_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_r == LPA_ST_SCAN && exe_r[LPA_CMD_START] && !exe_r[LPA_CMD_READ]) |=> run_r)
      else $error("start did not enable");
   stop_halts_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_r == LPA_ST_SCAN && exe_r[LPA_CMD_STOP] && !exe_r[LPA_CMD_START]) |=> !run_r)
      else $error("stop did not disable");
   reset_clears_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_r == LPA_ST_SCAN && exe_r[LPA_CMD_RESET] && !exe_r[LPA_CMD_READ])
      |=> (lo_r == '0 && hi_r == '0))
      else $error("reset did not clear");
   zero_cmd_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_r == LPA_ST_SCAN && exe_r == 8'h00) |=> (st_r == LPA_ST_IDLE && run_r == $past(run_r)))
      else $error("empty command acted");
   held_cmd_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_r == LPA_ST_RD_HI && cmd_full_r) |=> cmd_full_r)
      else $error("command taken during read wait");
   newmode_exit_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_r == LPA_ST_IDLE && cmd_full_r && cmd_r[LPA_CMD_NEWMODE]) |=> (st_r == LPA_ST_MODE && !run_r))
      else $error("mode change not taken");
   irq_status_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      irq_o |-> (irq_hw_en_i || $past(irq_hw_en_i)) && $past(sel_r[LPA_SEL_IRQ_STAT]))
      else $error("irq without enable");
endmodule

// ==== hw/lpa_pkg.sv ====
// package: constants and carrier types for the linear pulse accumulator channel
package lpa_pkg;
   // ====================================================
   // modes and command layout
   localparam logic [7:0] LPA_MODE_LINEAR = 8'h03;
   localparam int LPA_PARAM_LEN = 16;
   localparam int LPA_INPUT_SELECT_BYTE_IDX = 0;
   localparam int LPA_CMD_NEWMODE = 7;
   localparam int LPA_CMD_STOP = 6;
   localparam int LPA_CMD_READ = 5;
   localparam int LPA_CMD_RESET = 4;
   localparam int LPA_CMD_START = 3;
   localparam logic [7:0] LPA_CMD_RSVD_MASK = 8'h07;
   // input select byte fields
   localparam int LPA_SEL_RATE_LO = 0;
   localparam int LPA_SEL_DIR = 2;
   localparam int LPA_SEL_IRQ_DATA = 3;
   localparam int LPA_SEL_IRQ_STAT = 4;
   localparam logic [1:0] LPA_RATE_X1 = 2'h0;
   localparam logic [1:0] LPA_RATE_X2 = 2'h1;
   localparam logic [1:0] LPA_RATE_X4 = 2'h2;
   // status byte
   localparam int LPA_STAT_BADCMD = 0;
   localparam logic [7:0] LPA_STAT_ERR_MASK = 8'h01;
   // rates
   localparam int LPA_CLK_HZ = 25000000;
   localparam int LPA_MAX_COUNT_HZ = 200000;
   localparam int LPA_MIN_EDGE_CYC = LPA_CLK_HZ / LPA_MAX_COUNT_HZ;

   typedef enum logic [2:0] {
      LPA_ST_MODE = 3'b000,
      LPA_ST_PARAM = 3'b001,
      LPA_ST_IDLE = 3'b010,
      LPA_ST_SCAN = 3'b011,
      LPA_ST_RD_HI = 3'b100,
      LPA_ST_RD_LO = 3'b101
   } lpa_state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } lpa_byte_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } lpa_word_t;
endpackage

// ==== dv/lpa_host_model.sv ====
// bus master model for the channel's handshaked buffers
`timescale 1ns/10ps
module lpa_host_model import lpa_pkg::*; (
   // clock
   input wire logic clk_sys_i,
   // device side
   input wire logic cmd_full_i,
   input wire lpa_word_t result_out_i,
   input wire lpa_byte_t status_out_i,
   // master side
   output lpa_byte_t cmd_in_o,
   output logic result_take_o,
   output logic status_take_o
);
   // ============================
   // handshake tasks, entered 1 ns after an edge
   initial begin
      cmd_in_o = '0;
      result_take_o = 1'b0;
      status_take_o = 1'b0;
   end
   function automatic logic rdy(input int k);
      if (k == 0) return cmd_full_i === 1'b0;
      if (k == 1) return result_out_i.valid === 1'b1;
      return status_out_i.valid === 1'b1;
   endfunction
   task automatic await(input int k);
      int n;
      n = 0;
      while (!rdy(k) && n < 400) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      if (!rdy(k)) tb_top.timeout(k);
   endtask
   task automatic send(input logic [7:0] b);
      await(0);
      cmd_in_o = '{valid: 1'b1, data: b};
      @(posedge clk_sys_i);
      #1;
      // no stale byte left on the data lines
      cmd_in_o = '{valid: 1'b0, data: ~b};
   endtask
   task automatic take(input int k, output logic [15:0] v);
      await(k);
      v = (k == 1) ? result_out_i.data : {8'h00, status_out_i.data};
      result_take_o = (k == 1);
      status_take_o = (k != 1);
      @(posedge clk_sys_i);
      #1;
      result_take_o = 1'b0;
      status_take_o = 1'b0;
      // one idle edge keeps back-to-back takes apart
      @(posedge clk_sys_i);
      #1;
   endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the linear pulse accumulator channel
`timescale 1ns/10ps
module tb_top import lpa_pkg::*; ;
   // short halves keep the wrap test brief
   localparam int CNT_W = 4;
   localparam int FULL = 2 ** (2 * CNT_W);
   localparam int HALF = 2 ** CNT_W;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic tach_a = 1'b0;
   logic tach_b = 1'b0;
   logic irq_hw_en = 1'b1;
   lpa_byte_t cmd_in;
   lpa_byte_t status_out;
   lpa_word_t result_out;
   logic cmd_full, result_take, status_take, irq, running, linear_mode;
   logic [1:0] ph = 2'h0;
   int fails = 0;
   int checked = 0;
   int cnt = 0;
   int rate4 = 0;
   bit run = 0;
   lpa_channel #(.CNT_W(CNT_W)) dut (.clk_sys_i(clk_sys), .reset_n_i(reset_n),
      .tach_a_i(tach_a), .tach_b_i(tach_b), .cmd_in_i(cmd_in), .cmd_full_o(cmd_full),
      .result_out_o(result_out), .result_take_i(result_take), .status_out_o(status_out),
      .status_take_i(status_take), .irq_hw_en_i(irq_hw_en), .irq_o(irq),
      .running_o(running), .linear_mode_o(linear_mode));
   lpa_host_model host (.clk_sys_i(clk_sys), .cmd_full_i(cmd_full),
      .result_out_i(result_out), .status_out_i(status_out), .cmd_in_o(cmd_in),
      .result_take_o(result_take), .status_take_o(status_take));
   // ============================
   // helpers
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic timeout(input int k);
      fails++;
      $display("CHECK FAILED buffer %0d expected ready seen timeout", k);
      summarize();
   endtask
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         #1;
      end
   endtask
   // quadrature steps at the highest legal counting rate
   task automatic edges(input int n, input bit rev);
      for (int i = 0; i < n; i++) begin
         ph = rev ? ph - 2'h1 : ph + 2'h1;
         tach_a = ph[1];
         tach_b = ph[1] ^ ph[0];
         step(LPA_MIN_EDGE_CYC);
      end
      if (run) cnt = (cnt + n * rate4 / 4) % FULL;
   endtask
   task automatic cmd(input logic [7:0] b, input logic [7:0] st);
      logic [15:0] v;
      host.send(b);
      host.take(2, v);
      chk("status", v, st);
   endtask
   task automatic words();
      logic [15:0] hi, lo, st;
      host.take(1, hi);
      host.take(1, lo);
      host.take(2, st);
      chk("upper word", hi, cnt / HALF);
      chk("lower word", lo, cnt % HALF);
   endtask
   task automatic rd(input logic [7:0] b);
      host.send(b);
      words();
   endtask
   task automatic init(input logic [1:0] rate, input int r4);
      host.send(LPA_MODE_LINEAR);
      host.send({3'h0, 1'b1, 2'h0, rate});
      for (int i = 1; i < LPA_PARAM_LEN; i++) host.send(8'h5a);
      host.await(0);
      step(4);
      chk("mode", linear_mode, 1'b1);
      chk("running", running, 1'b0);
      cnt = 0;
      rate4 = r4;
      run = 0;
      rd(8'h20);
   endtask
   // ============================
   // scenarios
   task automatic t_basic();
      host.send(8'h05);
      host.await(0);
      step(4);
      chk("mode", linear_mode, 1'b0);
      init(LPA_RATE_X1, 1);
      cmd(8'h08, 8'h00);
      run = 1;
      edges(8, 0);
      edges(8, 1);
      rd(8'h20);
      cmd(8'h40, 8'h00);
      run = 0;
      edges(8, 0);
      cmd(8'h40, 8'h00);
      cmd(8'h00, 8'h00);
      chk("running", running, 1'b0);
      rd(8'h20);
      cmd(8'h08, 8'h00);
      run = 1;
      edges(4, 0);
      cmd(8'h08, 8'h00);
      rd(8'h20);
   endtask
   task automatic t_combo();
      rd(8'h30);
      cnt = 0;
      chk("running", running, 1'b1);
      edges(4, 0);
      host.send(8'h60);
      host.send(8'h08);
      step(10);
      chk("held command", cmd_full, 1'b1);
      chk("upper held", result_out.data, cnt / HALF);
      chk("running", running, 1'b0);
      run = 0;
      words();
      host.await(0);
      step(4);
      chk("running", running, 1'b1);
   endtask
   task automatic t_bad();
      logic [15:0] v;
      host.send(8'h01);
      host.await(2);
      step(2);
      chk("irq", irq, 1'b1);
      irq_hw_en = 1'b0;
      step(2);
      chk("irq", irq, 1'b0);
      irq_hw_en = 1'b1;
      host.send(8'h00);
      host.await(0);
      step(4);
      host.take(2, v);
      chk("status", v, 16'h0001);
      cmd(8'h02, 8'h01);
      cmd(8'h04, 8'h01);
      chk("running", running, 1'b1);
   endtask
   task automatic t_modes();
      cmd(8'hd8, 8'h00);
      chk("mode", linear_mode, 1'b0);
      init(LPA_RATE_X2, 2);
      cmd(8'h08, 8'h00);
      run = 1;
      edges(8, 0);
      rd(8'h20);
      cmd(8'h80, 8'h00);
      init(LPA_RATE_X4, 4);
      cmd(8'h08, 8'h00);
      run = 1;
      edges(FULL + 8, 1);
      rd(8'h20);
   endtask
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      step(1);
      t_basic();
      t_combo();
      t_bad();
      t_modes();
      summarize();
   end
endmodule
